// [hdl/core_map.svh]
// register offsets, field positions, reset values and timing counts
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH
`define CLKS_PER_ICYCLE 4
`define PH_LAST 2'h3
`define PC_W 11
`define DA_W 8
`define PCL_ADDR 8'h02
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_ACC 4'h8
`define REG_ICOUNT 4'hc
`define CTRL_RUN 0
`define CTRL_SEL_LO 1
`define CTRL_SEL_HI 2
`define CTRL_RST 3'h0
`define STAT_Z 16
`define STAT_C 17
`define STAT_BUSY 18
`define STAT_OPT_LSB 20
`define STAT_MATCH 22
`define OSC_8M 2'h0
`define OSC_12M 2'h1
`define OSC_16M 2'h2
`endif

// [hdl/core_pkg.sv]
// types shared by the core and its memories
`include "core_map.svh"
package core_pkg;
    typedef enum logic [4:0] {
        no_op = 5'h00, transfer_op = 5'h01, transfer_to_mem_op = 5'h02,
        transfer_imm_op = 5'h03, add_op = 5'h04, add_carry_op = 5'h05,
        sub_op = 5'h06, sub_borrow_op = 5'h07, add_imm_op = 5'h08,
        sub_imm_op = 5'h09, and_op = 5'h0a, or_op = 5'h0b, xor_op = 5'h0c,
        and_imm_op = 5'h0d, table_read_op = 5'h0e,
        subroutine_back_op = 5'h0f, invert_bits_op = 5'h10,
        add_one_in_place_op = 5'h11, add_one_to_acc_op = 5'h12,
        subtract_one_in_place_op = 5'h13, subtract_one_to_acc_op = 5'h14,
        rotate_right_op = 5'h15, rotate_left_op = 5'h16,
        rotate_right_thru_carry_op = 5'h17,
        rotate_left_thru_carry_op = 5'h18, bit_assert_op = 5'h19,
        bit_deassert_op = 5'h1a, skip_byte_op = 5'h1b,
        skip_bit_zero_op = 5'h1c, skip_bit_set_op = 5'h1d,
        unconditional_jump_op = 5'h1e, call_op = 5'h1f
    } op_t;

    // gray codes along idle -> exec -> extra
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_EXTRA = 2'b11
    } run_st_t;

    typedef struct packed {
        logic we;
        logic [`DA_W-1:0] addr;
        logic [7:0] data;
    } ram_wr_t;

    typedef struct packed {
        run_st_t st;
        logic [1:0] ph;
        logic [`PC_W-1:0] pc;
        logic [`PC_W-1:0] fetch_addr;
        logic [15:0] ir;
        logic [7:0] acc;
        logic z;
        logic c;
        logic [7:0] tab;
        logic [2:0] ctrl;
        logic [31:0] icount;
        logic waitreq;
        logic [31:0] rdata;
    } core_state_t;
endpackage

// [hdl/data_ram.sv]
// data memory with registered read port
`timescale 1ns/1ns
`default_nettype none
`include "core_map.svh"
module data_ram
    import core_pkg::*;
#(
    parameter int AW = `DA_W
) (
    input wire logic clk,
    input wire ram_wr_t wr,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata_q
);
    logic [7:0] mem [0:(1<<AW)-1];

    // no reset on the array; contents are undefined until written
    always_ff @(posedge clk) begin
        if (wr.we) begin
            mem[wr.addr] <= wr.data;
        end
        rdata_q <= mem[raddr];
    end
endmodule
`default_nettype wire

// [hdl/call_stack.sv]
// return address stack, shifting so the top sits in a register
`timescale 1ns/1ns
`default_nettype none
module call_stack #(
    parameter int DEPTH = 8,
    parameter int W = 11
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic push,
    input wire logic pop,
    input wire logic [W-1:0] din,
    output logic [W-1:0] top_q
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] ent;
    } stk_t;
    stk_t s_q, s_d;

    // past the last level the oldest entry falls off the bottom
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.ent = {s_q.ent[DEPTH-2:0], din};
        end else if (pop) begin
            s_d.ent = {{W{1'b0}}, s_q.ent[DEPTH-1:1]};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign top_q = s_q.ent[0];
endmodule
`default_nettype wire

// [hdl/mcu_instruction_timing_exec.sv]
// 8-bit core: four-clock instruction cycles, execution, avalon registers
// Notes on behaviour
// - one instruction cycle is exactly four system clocks
// - most instructions one cycle; jump, call, return, table read two
// - writing the program counter low byte costs one extra cycle
// - a taken skip costs one extra cycle, untaken none
// - add carries above 255, subtract borrows below zero
// - increment and decrement by one, to memory or accumulator
// - and, or, xor and invert set zero flag on zero result
// - rotates move one bit; carry variants swap bit through carry
// - call saves the next address, return resumes there
// - jump loads target and saves nothing
// - skips test a byte or bit and discard the next instruction
// - bit set and clear change only the addressed bit
// - moves: memory to acc, acc to memory, immediate to acc
// - the accumulator is one operand of every add, subtract, and, or and xor
// - fast oscillator frequency fixed at build: 8, 12 or 16 MHz
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "core_map.svh"
module mcu_instruction_timing_exec
    import core_pkg::*;
#(
    parameter logic [1:0] OSC_OPTION = `OSC_8M,
    parameter int STACK_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [`PC_W-1:0] fetch_addr,
    input wire logic [15:0] fetch_data
);
    core_state_t s_q, s_d;
    ram_wr_t ram_wr;
    logic [7:0] ram_rdata;
    logic [`PC_W-1:0] stk_top;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // memories
    // ------------------------------------------------------------
    data_ram #(.AW(`DA_W)) u_ram (
        .clk(clk),
        .wr(ram_wr),
        .raddr(s_q.ir[7:0]),
        .rdata_q(ram_rdata)
    );

    call_stack #(.DEPTH(STACK_DEPTH), .W(`PC_W)) u_stack (
        .clk(clk),
        .rstn(rstn),
        .push(push),
        .pop(pop),
        .din(s_q.pc + `PC_W'(1)),
        .top_q(stk_top)
    );

    // ------------------------------------------------------------
    // operand decode and datapath
    // ------------------------------------------------------------
    op_t op;
    logic dst_m;
    logic [2:0] bidx;
    logic [7:0] maddr;
    logic [7:0] mval;
    logic [7:0] opnd;
    logic [8:0] sum9;
    logic [8:0] dif9;
    logic [7:0] res;
    logic wr_m;
    logic wr_a;
    logic upd_z;
    logic c_n;
    logic skip;
    logic extra;
    logic [`PC_W-1:0] pc_n;
    logic commit;
    logic [31:0] rd;

    assign op = op_t'(s_q.ir[15:11]);
    assign dst_m = s_q.ir[8];
    assign bidx = s_q.ir[10:8];
    assign maddr = s_q.ir[7:0];
    // the low program counter byte reads as a data location
    assign mval = (maddr == `PCL_ADDR) ? s_q.pc[7:0] : ram_rdata;
    assign opnd = (op == add_imm_op || op == sub_imm_op ||
                   op == and_imm_op) ? maddr : mval;
    // nine bits keep the carry and the borrow out of the top
    assign sum9 = {1'b0, s_q.acc} + {1'b0, opnd} +
                  {8'h00, (op == add_carry_op) & s_q.c};
    assign dif9 = {1'b0, s_q.acc} - {1'b0, opnd} -
                  {8'h00, (op == sub_borrow_op) & s_q.c};
    assign commit = (s_q.st == ST_EXEC) && (s_q.ph == `PH_LAST);

    // per-opcode result, destinations, flags and flow
    always_comb begin
        res = 8'h00;
        wr_m = 1'b0;
        wr_a = 1'b0;
        upd_z = 1'b0;
        c_n = s_q.c;
        skip = 1'b0;
        extra = 1'b0;
        pc_n = s_q.pc + `PC_W'(1);
        case (op)
            transfer_op: begin
                res = mval;
                wr_a = 1'b1;
            end
            transfer_to_mem_op: begin
                res = s_q.acc;
                wr_m = 1'b1;
            end
            transfer_imm_op: begin
                res = maddr;
                wr_a = 1'b1;
            end
            add_op, add_carry_op, add_imm_op: begin
                res = sum9[7:0];
                c_n = sum9[8];
                upd_z = 1'b1;
                wr_m = dst_m & (op != add_imm_op);
                wr_a = ~wr_m;
            end
            sub_op, sub_borrow_op, sub_imm_op: begin
                res = dif9[7:0];
                c_n = dif9[8];
                upd_z = 1'b1;
                wr_m = dst_m & (op != sub_imm_op);
                wr_a = ~wr_m;
            end
            and_op, or_op, xor_op, and_imm_op: begin
                res = (op == or_op) ? (s_q.acc | opnd) :
                      (op == xor_op) ? (s_q.acc ^ opnd) : (s_q.acc & opnd);
                upd_z = 1'b1;
                wr_m = dst_m & (op != and_imm_op);
                wr_a = ~wr_m;
            end
            invert_bits_op: begin
                res = ~mval;
                upd_z = 1'b1;
                wr_m = dst_m;
                wr_a = ~dst_m;
            end
            add_one_in_place_op, add_one_to_acc_op: begin
                res = mval + 8'h01;
                upd_z = 1'b1;
                wr_m = (op == add_one_in_place_op);
                wr_a = ~wr_m;
            end
            subtract_one_in_place_op, subtract_one_to_acc_op: begin
                res = mval - 8'h01;
                upd_z = 1'b1;
                wr_m = (op == subtract_one_in_place_op);
                wr_a = ~wr_m;
            end
            rotate_right_op, rotate_left_op: begin
                res = (op == rotate_right_op) ? {mval[0], mval[7:1]}
                                              : {mval[6:0], mval[7]};
                wr_m = dst_m;
                wr_a = ~dst_m;
            end
            rotate_right_thru_carry_op: begin
                res = {s_q.c, mval[7:1]};
                c_n = mval[0];
                wr_m = dst_m;
                wr_a = ~dst_m;
            end
            rotate_left_thru_carry_op: begin
                res = {mval[6:0], s_q.c};
                c_n = mval[7];
                wr_m = dst_m;
                wr_a = ~dst_m;
            end
            bit_assert_op, bit_deassert_op: begin
                res = mval;
                res[bidx] = (op == bit_assert_op);
                wr_m = 1'b1;
            end
            skip_byte_op: begin
                skip = dst_m ? (mval != 8'h00) : (mval == 8'h00);
            end
            skip_bit_zero_op: begin
                skip = ~mval[bidx];
            end
            skip_bit_set_op: begin
                skip = mval[bidx];
            end
            unconditional_jump_op, call_op: begin
                pc_n = s_q.ir[`PC_W-1:0];
                extra = 1'b1;
            end
            subroutine_back_op: begin
                pc_n = stk_top;
                extra = 1'b1;
            end
            table_read_op: begin
                extra = 1'b1;
            end
            no_op: begin
            end
            default: begin
            end
        endcase
        // a written low byte acts as a jump inside the current page
        if (wr_m && maddr == `PCL_ADDR) begin
            pc_n = {s_q.pc[`PC_W-1:8], res};
            extra = 1'b1;
        end
        // the skipped word is never fetched; its slot is the extra cycle
        if (skip) begin
            pc_n = s_q.pc + `PC_W'(2);
            extra = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // register readback
    // ------------------------------------------------------------
    always_comb begin
        rd = 32'h0000_0000;
        case (avs_address)
            `REG_CTRL: rd[2:0] = s_q.ctrl;
            `REG_STATUS: begin
                rd[`PC_W-1:0] = s_q.pc;
                rd[`STAT_Z] = s_q.z;
                rd[`STAT_C] = s_q.c;
                rd[`STAT_BUSY] = (s_q.st != ST_IDLE);
                rd[`STAT_OPT_LSB+1:`STAT_OPT_LSB] = OSC_OPTION;
                rd[`STAT_MATCH] = (s_q.ctrl[`CTRL_SEL_HI:`CTRL_SEL_LO] ==
                                   OSC_OPTION);
            end
            `REG_ACC: rd[7:0] = s_q.acc;
            `REG_ICOUNT: rd = s_q.icount;
            default: rd = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // sequencing and bus slave
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        ram_wr = '0;
        push = 1'b0;
        pop = 1'b0;
        // four phases per instruction cycle: fetch, read, compute, commit
        if (s_q.st != ST_IDLE) begin
            s_d.ph = s_q.ph + 2'h1;
        end
        if (s_q.st != ST_IDLE && s_q.ph == `PH_LAST) begin
            s_d.icount = s_q.icount + 32'h1;
        end
        case (s_q.st)
            ST_IDLE: begin
                if (s_q.ctrl[`CTRL_RUN]) begin
                    s_d.st = ST_EXEC;
                    s_d.ph = 2'h0;
                end
            end
            ST_EXEC: begin
                if (s_q.ph == 2'h0) begin
                    s_d.ir = fetch_data;
                end
                if (commit) begin
                    if (wr_a) begin
                        s_d.acc = res;
                    end
                    if (upd_z) begin
                        s_d.z = (res == 8'h00);
                    end
                    s_d.c = c_n;
                    if (wr_m && maddr != `PCL_ADDR) begin
                        ram_wr = '{we: 1'b1, addr: maddr, data: res};
                    end
                    push = (op == call_op);
                    pop = (op == subroutine_back_op);
                    s_d.pc = pc_n;
                    // a table read points the fetch port at the acc word;
                    // other two-cycle ops hold the address until the end
                    s_d.fetch_addr = (op == table_read_op) ?
                        {{(`PC_W-8){1'b0}}, s_q.acc} :
                        (extra ? s_q.fetch_addr : pc_n);
                    s_d.st = extra ? ST_EXTRA :
                             (s_q.ctrl[`CTRL_RUN] ? ST_EXEC : ST_IDLE);
                end
            end
            ST_EXTRA: begin
                if (s_q.ph == 2'h1) begin
                    s_d.tab = fetch_data[7:0];
                end
                if (s_q.ph == `PH_LAST) begin
                    if (op == table_read_op) begin
                        ram_wr = '{we: 1'b1, addr: maddr, data: s_q.tab};
                    end
                    s_d.fetch_addr = s_q.pc;
                    s_d.st = s_q.ctrl[`CTRL_RUN] ? ST_EXEC : ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
                s_d.ph = 2'h0;
            end
        endcase
        // one wait cycle, then a single answer cycle with data
        s_d.waitreq = 1'b1;
        if ((avs_read || avs_write) && s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            s_d.rdata = avs_read ? rd : 32'h0000_0000;
        end
        // the write lands on the edge where the master sees the answer
        if (avs_write && !s_q.waitreq && avs_address == `REG_CTRL &&
            avs_byteenable[0]) begin
            s_d.ctrl = avs_writedata[2:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{st: ST_IDLE, ctrl: `CTRL_RST, waitreq: 1'b1,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign fetch_addr = s_q.fetch_addr;
endmodule
`default_nettype wire

// [verif/exec_timing_sva.sv]
// concurrent checks on the core's register bus and program fetch ports
`timescale 1ns/1ns
`default_nettype none
`include "core_map.svh"
module exec_timing_sva
    import core_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [`PC_W-1:0] fetch_addr,
    input wire logic [15:0] fetch_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ------------
    // fetch timing
    // ------------
    // opcode of the word latched one clock after the address moves
    logic [4:0] op;
    assign op = fetch_data[15:11];

    chk_cycle_hold: assert property ($changed(fetch_addr)
        |=> $stable(fetch_addr)[*3])
        else $error("fetch address moved inside an instruction cycle");
    // immediate ops never touch memory, so they can never branch
    chk_plain_step: assert property ($changed(fetch_addr) ##1
        (op inside {transfer_imm_op, add_imm_op, sub_imm_op, and_imm_op})
        |=> $stable(fetch_addr)[*2] ##1
        (fetch_addr == $past(fetch_addr) + 11'h1))
        else $error("immediate op did not step to the next word");
    chk_jump_target: assert property ($changed(fetch_addr) ##1
        (op == unconditional_jump_op)
        |=> $stable(fetch_addr)[*6] ##1
        (fetch_addr == $past(fetch_data[10:0])))
        else $error("jump took wrong time or target");
    chk_call_target: assert property ($changed(fetch_addr) ##1
        (op == call_op)
        |=> $stable(fetch_addr)[*6] ##1
        (fetch_addr == $past(fetch_data[10:0])))
        else $error("call took wrong time or target");
    chk_return_length: assert property ($changed(fetch_addr) ##1
        (op == subroutine_back_op)
        |=> $stable(fetch_addr)[*6] ##1 $changed(fetch_addr))
        else $error("return did not take two instruction cycles");
    chk_table_length: assert property ($changed(fetch_addr) ##1
        (op == table_read_op)
        |=> $stable(fetch_addr)[*2] ##5
        (fetch_addr == $past(fetch_addr, 8) + 11'h1))
        else $error("table read did not take two instruction cycles");
    chk_pcl_write: assert property ($changed(fetch_addr) ##1
        (op == transfer_to_mem_op && fetch_data[7:0] == `PCL_ADDR)
        |=> $stable(fetch_addr)[*6])
        else $error("low pc write finished in one instruction cycle");
    // a skip either steps once after four clocks or twice after eight
    chk_skip_length: assert property ($changed(fetch_addr) ##1
        (op inside {skip_byte_op, skip_bit_zero_op, skip_bit_set_op})
        |=> $stable(fetch_addr)[*2] ##1
        ((fetch_addr == $past(fetch_addr) + 11'h1) or
        ($stable(fetch_addr)[*4] ##1
        (fetch_addr == $past(fetch_addr) + 11'h2))))
        else $error("skip took wrong time or landed wrongly");

    // ------------
    // register bus
    // ------------
    chk_bus_answer: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered on the next clock");
    chk_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer lasted more than one clock");
endmodule
`default_nettype wire

// [verif/test_mcu_instruction_timing_exec.sv]
// self-checking bench for the instruction timing and execution core
`timescale 1ns/1ns
`default_nettype none
`include "core_map.svh"
module test_mcu_instruction_timing_exec
    import core_pkg::*;
();
    typedef struct packed {
        op_t op;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] acc;
        logic [1:0] cz;
    } row_t;
    logic clk;
    logic rstn;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [`PC_W-1:0] fetch_addr;
    logic [15:0] fetch_data;
    logic [15:0] rom [0:63];
    logic [15:0] prog [0:20];
    logic [31:0] rd;
    row_t rows [0:18];
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;

    mcu_instruction_timing_exec i_mcu_instruction_timing_exec (
        .clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fetch_addr(fetch_addr), .fetch_data(fetch_data)
    );
    // combinational program memory keeps the fetch answer in time
    assign fetch_data = rom[fetch_addr[5:0]];

    // -------
    // helpers
    // -------
    function automatic logic [15:0] ins(op_t o, logic [2:0] f,
        logic [7:0] m);
        return {o, f, m};
    endfunction

    // holds the request until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] wd, input logic [3:0] be, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk);
        while (avs_waitrequest) @(posedge clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic restart;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
    endtask

    task finish_test;
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // a hang costs a mismatch; the full run needs under 1500 clocks
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            finish_test();
        end
    end

    // -----
    // tests
    // -----
    initial begin
        rstn = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        foreach (rom[i]) rom[i] = 16'h0000;
        // op, memory byte, accumulator, result, {carry, zero}
        rows = '{
            '{add_op, 8'h80, 8'h80, 8'h00, 2'h3},
            '{add_op, 8'h01, 8'hfe, 8'hff, 2'h0},
            '{sub_op, 8'h05, 8'h03, 8'hfe, 2'h2},
            '{sub_op, 8'h03, 8'h03, 8'h00, 2'h1},
            '{add_imm_op, 8'h11, 8'hf8, 8'h08, 2'h2},
            '{sub_imm_op, 8'h11, 8'h10, 8'h00, 2'h1},
            '{and_op, 8'hf0, 8'h0f, 8'h00, 2'h1},
            '{or_op, 8'h0f, 8'h30, 8'h3f, 2'h0},
            '{xor_op, 8'h5a, 8'h5a, 8'h00, 2'h1},
            '{and_imm_op, 8'h11, 8'h01, 8'h00, 2'h1},
            '{invert_bits_op, 8'hff, 8'h00, 8'h00, 2'h1},
            '{add_one_to_acc_op, 8'hff, 8'h00, 8'h00, 2'h1},
            '{subtract_one_to_acc_op, 8'h00, 8'h00, 8'hff, 2'h0},
            '{subtract_one_in_place_op, 8'h01, 8'h55, 8'h55, 2'h1},
            '{rotate_right_op, 8'h01, 8'h00, 8'h80, 2'h0},
            '{rotate_left_op, 8'h81, 8'h00, 8'h03, 2'h0},
            '{rotate_right_thru_carry_op, 8'h01, 8'h00, 8'h00, 2'h2},
            '{rotate_left_thru_carry_op, 8'hc0, 8'h00, 8'h80, 2'h2},
            '{transfer_op, 8'h77, 8'h00, 8'h77, 2'h0}};
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, `REG_CTRL, 32'h0, 4'hf, rd);
        check(rd, 32'h0);
        bus(1'b0, `REG_STATUS, 32'h0, 4'hf, rd);
        check(rd, 32'h0040_0000);
        bus(1'b0, `REG_ICOUNT, 32'h0, 4'hf, rd);
        check(rd, 32'h0);
        // every oscillator select, only the built-in one matches
        for (int s = 0; s < 3; s++) begin
            bus(1'b1, `REG_CTRL, 32'(s << 1), 4'h1, rd);
            bus(1'b0, `REG_STATUS, 32'h0, 4'hf, rd);
            check({29'h0, rd[22:20]}, {29'h0, s == 0, 2'h0});
        end
        bus(1'b1, `REG_CTRL, 32'h1, 4'he, rd);
        bus(1'b0, `REG_CTRL, 32'h0, 4'hf, rd);
        check(rd, 32'h4);
        bus(1'b0, 4'h2, 32'h0, 4'hf, rd);
        check(rd, 32'h0);
        // byte staged through memory, accumulator reloaded, then the op
        foreach (rows[i]) begin
            restart();
            rom[0] = ins(transfer_imm_op, 3'h0, rows[i].a);
            rom[1] = ins(transfer_to_mem_op, 3'h0, 8'h10);
            rom[2] = ins(transfer_imm_op, 3'h0, rows[i].b);
            rom[3] = ins(rows[i].op,
                {2'h0, rows[i].op == subtract_one_in_place_op}, 8'h10);
            rom[4] = ins(unconditional_jump_op, 3'h0, 8'h04);
            bus(1'b1, `REG_CTRL, 32'h1, 4'h1, rd);
            while (fetch_addr !== 11'h004) @(negedge clk);
            bus(1'b0, `REG_ACC, 32'h0, 4'hf, rd);
            check(rd, {24'h0, rows[i].acc});
            bus(1'b0, `REG_STATUS, 32'h0, 4'hf, rd);
            check({30'h0, rd[17:16]}, {30'h0, rows[i].cz});
        end
        // skips taken and not, bit edits, call, low pc write, table
        prog = '{ins(transfer_imm_op, 3'h0, 8'h00),
            ins(transfer_to_mem_op, 3'h0, 8'h11),
            ins(skip_byte_op, 3'h0, 8'h11), 16'h0000,
            ins(skip_byte_op, 3'h1, 8'h11),
            ins(transfer_imm_op, 3'h0, 8'ha5),
            ins(transfer_to_mem_op, 3'h0, 8'h11),
            ins(bit_deassert_op, 3'h0, 8'h11),
            ins(bit_assert_op, 3'h3, 8'h11),
            ins(skip_bit_set_op, 3'h3, 8'h11), 16'h0000,
            ins(skip_bit_zero_op, 3'h0, 8'h11), 16'h0000,
            ins(skip_bit_zero_op, 3'h2, 8'h11),
            ins(call_op, 3'h0, 8'h30),
            ins(transfer_imm_op, 3'h0, 8'h12),
            ins(transfer_to_mem_op, 3'h0, `PCL_ADDR), 16'h0000,
            ins(table_read_op, 3'h0, 8'h13),
            ins(transfer_op, 3'h0, 8'h13),
            ins(unconditional_jump_op, 3'h0, 8'h14)};
        restart();
        foreach (prog[i]) rom[i] = prog[i];
        rom[48] = ins(subroutine_back_op, 3'h0, 8'h00);
        bus(1'b1, `REG_CTRL, 32'h1, 4'h1, rd);
        while (fetch_addr === 11'h000) @(negedge clk);
        n = 0;
        while (fetch_addr !== 11'h014) begin
            @(negedge clk);
            n++;
        end
        // 23 instruction cycles of four clocks after the first word
        check(32'(n), 32'h5c);
        bus(1'b0, `REG_ACC, 32'h0, 4'hf, rd);
        check(rd, 32'h13);
        bus(1'b0, `REG_STATUS, 32'h0, 4'hf, rd);
        check({21'h0, rd[10:0]}, 32'h14);
        finish_test();
    end
endmodule

bind mcu_instruction_timing_exec exec_timing_sva i_exec_timing_sva (
    .clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fetch_addr(fetch_addr), .fetch_data(fetch_data)
);
`default_nettype wire
